/* verilog/mpfs_pkg.sv */
// Package for the mode and pin function select block.
// Assumes one hclk domain; software registers reached over AHB-Lite.
package mpfs_pkg;

  // Operating modes, from the two strap pins {high, low}
  typedef enum logic [1:0] {
    MPFS_MODE_BOOT     = 2'b00,
    MPFS_MODE_SINGLE   = 2'b01,
    MPFS_MODE_TEST     = 2'b10,
    MPFS_MODE_EXPANDED = 2'b11
  } mpfs_mode_t;

  // Register byte offsets
  localparam logic [7:0] MPFS_OFF_CTRL   = 8'h00;
  localparam logic [7:0] MPFS_OFF_STATUS = 8'h04;
  localparam logic [7:0] MPFS_OFF_PORTB  = 8'h08;
  localparam logic [7:0] MPFS_OFF_PORTC  = 8'h0C;
  localparam logic [7:0] MPFS_OFF_PORTD  = 8'h10;
  localparam logic [7:0] MPFS_OFF_PORTA  = 8'h14;
  localparam logic [7:0] MPFS_OFF_BUSCYC = 8'h18;
  localparam logic [7:0] MPFS_OFF_ADDRQ  = 8'h1C;

  // Control register fields
  localparam int MPFS_CTRL_PMEN   = 0;
  localparam int MPFS_CTRL_NMIMSK = 1;
  localparam int MPFS_CTRL_ISTART = 2;

  // Status register fields
  localparam int MPFS_ST_MODE_LO  = 0;
  localparam int MPFS_ST_PMEN     = 2;
  localparam int MPFS_ST_NMIMSK   = 3;
  localparam int MPFS_ST_NMIREQ   = 4;
  localparam int MPFS_ST_SPECIAL  = 5;
  localparam int MPFS_ST_LOCKED   = 6;
  localparam int MPFS_ST_BUSY     = 7;
  localparam int MPFS_ST_DEC      = 8;

  // Port register halves: data in [7:0], direction in [15:8]
  localparam int MPFS_PDIR_LSB = 8;

  // Port D bits shared with the bus strobes
  localparam int MPFS_PD_STROBE = 6;
  localparam int MPFS_PD_RW     = 7;

  // Port A: bits 0..2 input only, 3 and 7 bidirectional, 4..6 output only
  localparam logic [7:0] MPFS_PA_OUT_ONLY = 8'h70;
  localparam logic [7:0] MPFS_PA_BIDIR    = 8'h88;

  // Program memory windows (upper nibble of a 16-bit address)
  localparam logic [3:0] MPFS_PM_BASE_EXP = 4'h7;
  localparam logic [3:0] MPFS_PM_BASE_STD = 4'hF;

  // Bus cycle command fields: [15:0] address, [23:16] data, [24] read
  localparam int MPFS_CYC_DATA_LSB = 16;
  localparam int MPFS_CYC_READ     = 24;

  // AHB transfer type
  localparam logic [1:0] MPFS_HTRANS_NONSEQ = 2'h2;

  // External bus pin group
  typedef struct packed {
    logic [7:0] b_o;
    logic [7:0] b_oe;
    logic [7:0] c_o;
    logic [7:0] c_oe;
    logic [7:0] d_o;
    logic [7:0] d_oe;
  } mpfs_pins_t;

endpackage

/* verilog/mpfs_top.sv */
// Mode select, shared-pin routing, program memory map and bus muxing.
// Assumes straps and port pins are asynchronous; an AHB-Lite master on
// hclk; an external latch capturing port C low address on the strobe.
// Functional notes
// - Latch one of four modes at reset release
// - Instruction-start low for first cycle only
// - R/W pin: port D bit seven or direction
// - Strobe pin: port D bit six or strobe
// - Port C multiplexes low address and data
// - B, C, strobes general I/O only in non-bus modes
// - Port A: two bidir, three in, three out
// - B, C, D lines per-bit bidirectional
// - Reset sets the nonmaskable interrupt mask
// - Nonmaskable request asynchronous, level, active low
// - Program memory enabled on leaving reset
// - Enable writable once unless special mode
// - Enable bit gates program memory decode
// - Window at 7000 expanded, else F000
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module mpfs_top
  import mpfs_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Mode straps and instruction-start debug pin
  input  wire logic        mode_select_low,
  input  wire logic        mode_select_high,
  output logic             instr_start_n_o,
  output logic             instr_start_n_oe,
  // Instruction-start event from the core, same clock
  input  wire logic        instr_first_cycle,
  // Nonmaskable request pin
  input  wire logic        nonmaskable_irq_n,
  output logic             nmi_request,
  // Program memory decode for the core address
  input  wire logic [15:0] core_addr,
  output logic             prog_mem_select,
  // Port A
  input  wire logic [7:0]  port_a_i,
  output logic [7:0]       port_a_o,
  output logic [7:0]       port_a_oe,
  // Ports B, C, D pins
  input  wire logic [7:0]  port_b_i,
  input  wire logic [7:0]  port_c_i,
  input  wire logic [7:0]  port_d_i,
  output mpfs_pins_t       pins
);

  // Decode helper: bus modes use external multiplexed bus
  function automatic logic is_bus_mode(input mpfs_mode_t m);
    is_bus_mode = (m == MPFS_MODE_EXPANDED) || (m == MPFS_MODE_TEST);
  endfunction

  // Decode helper: special modes allow free enable writes
  function automatic logic is_special(input mpfs_mode_t m);
    is_special = (m == MPFS_MODE_BOOT) || (m == MPFS_MODE_TEST);
  endfunction

  // Bus phases; the last three wait out the port C synchroniser
  typedef enum {MPFS_ST_IDLE, MPFS_ST_ADDR, MPFS_ST_DATA, MPFS_ST_PIN,
                MPFS_ST_SYNC, MPFS_ST_CAPT} mpfs_bus_st_t;

  // Synchronisers for asynchronous inputs
  logic [1:0]  mode_s1_q, mode_s2_q;     // Strap pins
  logic        nmi_s1_q, nmi_s2_q;       // Nonmaskable pin
  logic [7:0]  pa_s1_q, pa_s2_q;         // Port A inputs
  logic [7:0]  pb_s1_q, pb_s2_q;         // Port B inputs
  logic [7:0]  pc_s1_q, pc_s2_q;         // Port C inputs
  logic [7:0]  pd_s1_q, pd_s2_q;         // Port D inputs

  // Mode latch state
  mpfs_mode_t  mode_q, mode_d;           // Latched mode
  logic        mode_done_q, mode_done_d; // Latch taken since reset
  logic        armed_q, armed_d;         // Instruction-start active
  logic [1:0]  live_q, live_d;           // Edges seen since release

  // Control state
  logic        pmen_q, pmen_d;           // Program memory enable
  logic        pmen_wr_q, pmen_wr_d;     // One write consumed
  logic        nmimsk_q, nmimsk_d;       // Nonmaskable mask
  logic [15:0] pa_q, pa_d;               // Port A data/direction
  logic [15:0] pb_q, pb_d;               // Port B data/direction
  logic [15:0] pc_q, pc_d;               // Port C data/direction
  logic [15:0] pd_q, pd_d;               // Port D data/direction

  // External bus cycle engine
  mpfs_bus_st_t bst_q, bst_d;            // Bus phase
  logic [24:0] cyc_q, cyc_d;             // Command: addr, data, read
  logic [7:0]  rdat_q, rdat_d;           // Data read from port C

  // AHB data phase state
  logic        wr_pend_q, wr_pend_d;     // Write data phase pending
  logic [7:0]  wr_addr_q, wr_addr_d;     // Offset of pending write
  logic [31:0] hrdata_q, hrdata_d;       // Read data

  // Output registers
  logic        lir_q, lir_d;             // Instruction-start drive
  logic        nmireq_q, nmireq_d;       // Masked request out
  logic        pmsel_q, pmsel_d;         // Program memory select
  logic [7:0]  pao_q, pao_d, paoe_q, paoe_d;
  mpfs_pins_t  pins_q, pins_d;

  logic        ahb_take;                 // Valid address phase
  logic [3:0]  pm_base;                  // Window nibble

  assign ahb_take = hsel && hready && (htrans == MPFS_HTRANS_NONSEQ);
  assign pm_base  = (mode_q == MPFS_MODE_EXPANDED) ?
                    MPFS_PM_BASE_EXP : MPFS_PM_BASE_STD;

  // Two-flop synchronisers, nothing reads the first stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_s1_q <= 2'h0;
      mode_s2_q <= 2'h0;
      nmi_s1_q  <= 1'b1;
      nmi_s2_q  <= 1'b1;
      pa_s1_q   <= 8'h00;
      pa_s2_q   <= 8'h00;
      pb_s1_q   <= 8'h00;
      pb_s2_q   <= 8'h00;
      pc_s1_q   <= 8'h00;
      pc_s2_q   <= 8'h00;
      pd_s1_q   <= 8'h00;
      pd_s2_q   <= 8'h00;
    end else begin
      mode_s1_q <= {mode_select_high, mode_select_low};
      mode_s2_q <= mode_s1_q;
      nmi_s1_q  <= nonmaskable_irq_n;
      nmi_s2_q  <= nmi_s1_q;
      pa_s1_q   <= port_a_i;
      pa_s2_q   <= pa_s1_q;
      pb_s1_q   <= port_b_i;
      pb_s2_q   <= pb_s1_q;
      pc_s1_q   <= port_c_i;
      pc_s2_q   <= pc_s1_q;
      pd_s1_q   <= port_d_i;
      pd_s2_q   <= pd_s1_q;
    end
  end

  // Next state for mode, control, bus engine and register bus
  always_comb begin
    mode_d      = mode_q;
    mode_done_d = mode_done_q;
    armed_d     = armed_q;
    live_d      = {live_q[0], 1'b1};
    pmen_d      = pmen_q;
    pmen_wr_d   = pmen_wr_q;
    nmimsk_d    = nmimsk_q;
    pa_d        = pa_q;
    pb_d        = pb_q;
    pc_d        = pc_q;
    pd_d        = pd_q;
    bst_d       = bst_q;
    cyc_d       = cyc_q;
    rdat_d      = rdat_q;
    wr_pend_d   = 1'b0;
    wr_addr_d   = wr_addr_q;
    hrdata_d    = hrdata_q;
    // Strap sample once stage two holds pin values, third edge
    if (!mode_done_q && live_q[1]) begin
      mode_d      = mpfs_mode_t'(mode_s2_q);
      mode_done_d = 1'b1;
      armed_d     = 1'b1;
    end
    // External bus cycle: address phase then data phase
    case (bst_q)
      MPFS_ST_IDLE: bst_d = MPFS_ST_IDLE;
      MPFS_ST_ADDR: bst_d = MPFS_ST_DATA;
      MPFS_ST_DATA: bst_d = MPFS_ST_PIN;
      // Pins carry the data phase now; stage two sees it two edges on
      MPFS_ST_PIN:  bst_d = MPFS_ST_SYNC;
      MPFS_ST_SYNC: bst_d = MPFS_ST_CAPT;
      MPFS_ST_CAPT: begin
        // Stage two holds the level sampled during the data phase
        if (cyc_q[MPFS_CYC_READ]) begin
          rdat_d = pc_s2_q;
        end
        bst_d = MPFS_ST_IDLE;
      end
      default:      bst_d = MPFS_ST_IDLE;
    endcase
    // Register write data phase
    if (wr_pend_q) begin
      case (wr_addr_q)
        MPFS_OFF_CTRL: begin
          // Once only in normal modes, freely in special modes
          if (is_special(mode_q) || !pmen_wr_q) begin
            pmen_d    = hwdata[MPFS_CTRL_PMEN];
            pmen_wr_d = 1'b1;
          end
          // Software may only clear the mask
          if (!hwdata[MPFS_CTRL_NMIMSK]) begin
            nmimsk_d = 1'b0;
          end
          armed_d = hwdata[MPFS_CTRL_ISTART];
        end
        MPFS_OFF_PORTA:  pa_d = hwdata[15:0];
        MPFS_OFF_PORTB:  pb_d = hwdata[15:0];
        MPFS_OFF_PORTC:  pc_d = hwdata[15:0];
        MPFS_OFF_PORTD:  pd_d = hwdata[15:0];
        MPFS_OFF_BUSCYC: begin
          // Only accepted in bus modes and when engine is idle
          if (is_bus_mode(mode_q) && (bst_q == MPFS_ST_IDLE)) begin
            cyc_d = hwdata[24:0];
            bst_d = MPFS_ST_ADDR;
          end
        end
        default: ;
      endcase
    end
    // Address phase decode
    if (ahb_take) begin
      wr_pend_d = hwrite;
      wr_addr_d = haddr[7:0];
      if (!hwrite) begin
        case (haddr[7:0])
          MPFS_OFF_CTRL:   hrdata_d = {29'h0, armed_q, nmimsk_q, pmen_q};
          MPFS_OFF_STATUS: hrdata_d = {20'h0, pm_base, bst_q !=
                             MPFS_ST_IDLE, pmen_wr_q, is_special(mode_q),
                             !nmi_s2_q, nmimsk_q, pmen_q, mode_q};
          MPFS_OFF_PORTA:  hrdata_d = {16'h0, pa_q[15:8], pa_s2_q};
          MPFS_OFF_PORTB:  hrdata_d = {16'h0, pb_q[15:8], pb_s2_q};
          MPFS_OFF_PORTC:  hrdata_d = {16'h0, pc_q[15:8], pc_s2_q};
          MPFS_OFF_PORTD:  hrdata_d = {16'h0, pd_q[15:8], pd_s2_q};
          MPFS_OFF_BUSCYC: hrdata_d = {7'h0, cyc_q};
          MPFS_OFF_ADDRQ:  hrdata_d = {24'h0, rdat_q};
          default:         hrdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  // Next values of the registered outputs
  always_comb begin
    pins_d = '0;
    // Instruction start pulled low only in the cycle after the core flags
    lir_d    = armed_q && instr_first_cycle;
    nmireq_d = !nmi_s2_q && !nmimsk_q;
    // Enable bit and window select the on-chip memory
    pmsel_d  = pmen_q && (core_addr[15:12] == pm_base);
    // Port A fixed lanes, direction only on the two bidir lines
    paoe_d = MPFS_PA_OUT_ONLY | (pa_q[15:8] & MPFS_PA_BIDIR);
    pao_d  = pa_q[7:0] & paoe_d;
    if (is_bus_mode(mode_q)) begin
      // High address on port B
      pins_d.b_o  = cyc_q[15:8];
      pins_d.b_oe = 8'hFF;
      // Low address in address phase, data after
      if (bst_q == MPFS_ST_ADDR) begin
        pins_d.c_o  = cyc_q[7:0];
        pins_d.c_oe = 8'hFF;
      end else if ((bst_q == MPFS_ST_DATA) && !cyc_q[MPFS_CYC_READ]) begin
        pins_d.c_o  = cyc_q[MPFS_CYC_DATA_LSB +: 8];
        pins_d.c_oe = 8'hFF;
      end
      pins_d.d_o  = pd_q[7:0];
      pins_d.d_oe = pd_q[15:8];
      // Strobe high during address phase
      pins_d.d_o[MPFS_PD_STROBE]  = (bst_q == MPFS_ST_ADDR);
      pins_d.d_oe[MPFS_PD_STROBE] = 1'b1;
      // Direction: high for read, idle reads as read
      pins_d.d_o[MPFS_PD_RW]  = (bst_q == MPFS_ST_IDLE) ||
                                cyc_q[MPFS_CYC_READ];
      pins_d.d_oe[MPFS_PD_RW] = 1'b1;
    end else begin
      // Plain per-bit I/O on all three ports
      pins_d.b_o  = pb_q[7:0];
      pins_d.b_oe = pb_q[15:8];
      pins_d.c_o  = pc_q[7:0];
      pins_d.c_oe = pc_q[15:8];
      pins_d.d_o  = pd_q[7:0];
      pins_d.d_oe = pd_q[15:8];
    end
  end

  // State registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q      <= MPFS_MODE_BOOT;
      mode_done_q <= 1'b0;
      armed_q     <= 1'b0;
      live_q      <= 2'h0;
      pmen_q      <= 1'b1;
      pmen_wr_q   <= 1'b0;
      nmimsk_q    <= 1'b1;
      pa_q        <= 16'h0000;
      pb_q        <= 16'h0000;
      pc_q        <= 16'h0000;
      pd_q        <= 16'h0000;
      bst_q       <= MPFS_ST_IDLE;
      cyc_q       <= 25'h0000000;
      rdat_q      <= 8'h00;
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
      lir_q       <= 1'b0;
      nmireq_q    <= 1'b0;
      pmsel_q     <= 1'b0;
      pao_q       <= 8'h00;
      paoe_q      <= 8'h00;
      pins_q      <= '0;
    end else begin
      mode_q      <= mode_d;
      mode_done_q <= mode_done_d;
      armed_q     <= armed_d;
      live_q      <= live_d;
      pmen_q      <= pmen_d;
      pmen_wr_q   <= pmen_wr_d;
      nmimsk_q    <= nmimsk_d;
      pa_q        <= pa_d;
      pb_q        <= pb_d;
      pc_q        <= pc_d;
      pd_q        <= pd_d;
      bst_q       <= bst_d;
      cyc_q       <= cyc_d;
      rdat_q      <= rdat_d;
      wr_pend_q   <= wr_pend_d;
      wr_addr_q   <= wr_addr_d;
      hrdata_q    <= hrdata_d;
      lir_q       <= lir_d;
      nmireq_q    <= nmireq_d;
      pmsel_q     <= pmsel_d;
      pao_q       <= pao_d;
      paoe_q      <= paoe_d;
      pins_q      <= pins_d;
    end
  end

  // Outputs straight from flops or tied off; slave never stalls, always OKAY
  assign hrdata           = hrdata_q;
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign instr_start_n_o  = 1'b0;   // Open drain: only pulls low
  assign instr_start_n_oe = lir_q;
  assign nmi_request      = nmireq_q;
  assign prog_mem_select  = pmsel_q;
  assign port_a_o         = pao_q;
  assign port_a_oe        = paoe_q;
  assign pins             = pins_q;

endmodule

/* bench/mpfs_properties.sv */
// Checker for the mode and pin select block, bound to its top module.
// Assumes every port is sampled on hclk and cleared by hresetn.
`timescale 1ns/100ps
module mpfs_properties
  import mpfs_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus answer
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Debug pin and its cause
  input wire logic        instr_start_n_o,
  input wire logic        instr_start_n_oe,
  input wire logic        instr_first_cycle,
  // Nonmaskable request
  input wire logic        nonmaskable_irq_n,
  input wire logic        nmi_request,
  // Program memory decode and port A
  input wire logic [15:0] core_addr,
  input wire logic        prog_mem_select,
  input wire logic [7:0]  port_a_oe
);
  logic [3:0] addr_top; // Upper nibble of the core address
  assign addr_top = core_addr[15:12];
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Slave is always ready and always answers OKAY
  chk_bus_ready_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  // Open-drain pin only ever pulls low
  chk_istart_drain: assert property (
    instr_start_n_oe |-> !instr_start_n_o)
    else $error("instruction start pin driven high");
  // Low only after an instruction start
  chk_istart_cause: assert property (
    instr_start_n_oe |-> $past(instr_first_cycle))
    else $error("instruction start low without a start");
  // Low for one cycle only
  chk_istart_width: assert property (
    instr_start_n_oe && !instr_first_cycle |=> !instr_start_n_oe)
    else $error("instruction start low too long");
  // Input-only lines of port A are never driven
  chk_pa_input_only: assert property (port_a_oe[2:0] == 3'h0)
    else $error("port A input line driven");
  // Output-only lines of port A always driven after reset
  chk_pa_output_only: assert property (
    $past(hresetn, 2) |-> port_a_oe[6:4] == 3'h7)
    else $error("port A output line not driven");
  // Request only follows a low level on the pin
  chk_nmi_cause: assert property (
    nmi_request |-> !$past(nonmaskable_irq_n, 3))
    else $error("nonmaskable request without low pin");
  // Program memory only decoded in one of its two windows
  chk_pm_window: assert property (
    prog_mem_select |-> $past(addr_top) inside {4'h7, 4'hF})
    else $error("program memory selected outside window");
endmodule

bind mpfs_top mpfs_properties i_mpfs_properties (.hclk, .hresetn, .hreadyout,
  .hresp, .instr_start_n_o, .instr_start_n_oe, .instr_first_cycle,
  .nonmaskable_irq_n, .nmi_request, .core_addr, .prog_mem_select, .port_a_oe);

/* bench/mpfs_ext_mem.sv */
// External multiplexed memory across ports B, C and D.
// Assumes the bench says when the pins carry the bus.
`timescale 1ns/100ps
module mpfs_ext_mem
  import mpfs_pkg::*;
(
  // Clock and device pins
  input wire logic       hclk,
  input wire mpfs_pins_t pins,
  // Bus mode and general I/O level from the bench
  input wire logic       bus_mode,
  input wire logic [7:0] gpio,
  // Port C level and captured transfer
  output logic [7:0]     port_c_i,
  output logic [15:0]    addr_q,
  output logic [7:0]     wdata_q
);
  logic       rd_q;   // Read data phase
  logic       wr_q;   // Write data phase
  logic [7:0] last_q; // Port C level one cycle ago
  logic [7:0] drv;    // What the memory puts on port C
  logic       strobe; // Address strobe seen
  assign strobe = bus_mode & pins.d_o[6];
  // Address taken on the strobe, data in the cycle after
  always_ff @(posedge hclk) begin
    rd_q   <= strobe & pins.d_o[7];
    wr_q   <= strobe & ~pins.d_o[7];
    last_q <= port_c_i;
    if (strobe) begin
      addr_q <= {pins.b_o, pins.c_o};
    end
    if (wr_q) begin
      wdata_q <= port_c_i;
    end
  end
  // Read byte in data phase; a released bus shows a toggling level
  assign drv = rd_q ? (addr_q[7:0] ^ addr_q[15:8] ^ 8'h5A) :
               bus_mode ? ~last_q : gpio;
  assign port_c_i = (pins.c_oe & pins.c_o) | (~pins.c_oe & drv);
endmodule

/* bench/testbench.sv */
// Self-checking bench for the mode and pin select block.
// Assumes an AHB-Lite master, the memory model and bench straps.
`timescale 1ns/100ps
module testbench;
  import mpfs_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, v, seen, x;
  logic [1:0] htrans = 0, mc = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, instr_start_n_o, instr_start_n_oe, nmi_request;
  logic mode_select_low = 0, mode_select_high = 0, prog_mem_select;
  logic instr_first_cycle = 0, nonmaskable_irq_n = 1;
  logic [15:0] core_addr = 0, a, addr_q;
  logic [7:0] port_a_i, port_a_o, port_a_oe, port_b_i, port_c_i, port_d_i;
  logic [7:0] gpio = 8'h00, d, wdata_q;
  logic [3:0] win;
  mpfs_pins_t pins;
  int fails = 0, check_count = 0, n;
  logic [31:0] exp_q[$];
  string nam_q[$];
  event got;
  // Pin levels: driven bits show the device, others the outside
  assign hready = hreadyout;
  assign port_a_i = (port_a_oe & port_a_o) | (~port_a_oe & gpio);
  assign port_b_i = (pins.b_oe & pins.b_o) | (~pins.b_oe & gpio);
  assign port_d_i = (pins.d_oe & pins.d_o) | (~pins.d_oe & gpio);
  always #12.5 hclk = ~hclk;
  mpfs_top i_mpfs_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .mode_select_low,
    .mode_select_high, .instr_start_n_o, .instr_start_n_oe,
    .instr_first_cycle, .nonmaskable_irq_n, .nmi_request, .core_addr,
    .prog_mem_select, .port_a_i, .port_a_o, .port_a_oe, .port_b_i, .port_c_i,
    .port_d_i, .pins);
  mpfs_ext_mem i_mpfs_ext_mem (.hclk, .pins, .bus_mode(mc[1]), .gpio,
    .port_c_i, .addr_q, .wdata_q);
  // Note an expectation, then hand over the observed value
  task chk(input string nm, input logic [31:0] e, input logic [31:0] o);
    exp_q.push_back(e);
    nam_q.push_back(nm);
    seen = o;
    ->got;
    #1;
  endtask
  // Oldest note compared against each observed value
  always @(got) begin
    check_count++;
    if (seen !== exp_q[0]) begin
      fails++;
      $display("Error %s expected %h seen %h", nam_q[0], exp_q[0], seen);
    end
    exp_q.delete(0);
    nam_q.delete(0);
  end
  // Wait for hready under a bound
  task wait_rdy;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    // A wait that runs out counts as a mismatch
    if (hreadyout !== 1'b1) begin
      fails++;
    end
  endtask
  // One single word transfer; read data lands in rd
  task ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= MPFS_HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {24'h0, ad};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  // Reset with straps, then move the straps away
  task rst(input logic [1:0] m);
    @(posedge hclk);
    hresetn <= 1'b0;
    {mode_select_high, mode_select_low} <= m;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    {mode_select_high, mode_select_low} <= ~m;
  endtask
  task pm(input logic [15:0] ca, input logic e, input string nm);
    @(posedge hclk);
    core_addr <= ca;
    repeat (2) @(posedge hclk);
    #1;
    chk(nm, {31'h0, e}, {31'h0, prog_mem_select});
  endtask
  task results;
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #250000;
    fails++;
    results();
  end
  // Every mode in turn
  initial begin
    void'($urandom(32'hC8286F74));
    for (int m = 0; m < 4; m++) begin
      mc = m[1:0];
      win = (mc == 2'b11) ? MPFS_PM_BASE_EXP : MPFS_PM_BASE_STD;
      rst(mc);
      ahb(1'b0, MPFS_OFF_STATUS, 32'h0);
      v = {20'h0, win, 2'b00, ~mc[0], 3'b011, mc};
      chk("status", v, rd & 32'hFFF);
      pm({win, 12'h123}, 1'b1, "pm_in");
      pm(16'h3456, 1'b0, "pm_out");
      pm({win ^ 4'h8, 12'h123}, 1'b0, "pm_other");
      // Pin and core inputs change on a rising edge only
      @(posedge hclk);
      nonmaskable_irq_n <= 1'b0;
      repeat (6) @(posedge hclk);
      #1;
      chk("nmi_masked", 32'h0, {31'h0, nmi_request});
      ahb(1'b1, MPFS_OFF_CTRL, 32'h4);
      repeat (6) @(posedge hclk);
      #1;
      chk("nmi_req", 32'h1, {31'h0, nmi_request});
      pm({win, 12'h0FF}, 1'b0, "pm_off");
      ahb(1'b1, MPFS_OFF_CTRL, 32'h5);
      pm({win, 12'h0FF}, ~mc[0], "pm_rewrite");
      @(posedge hclk);
      nonmaskable_irq_n <= 1'b1;
      instr_first_cycle <= 1'b1;
      // Pin low in the cycle after the flag is taken, then released
      @(posedge hclk);
      instr_first_cycle <= 1'b0;
      #1;
      chk("istart", 32'h1, {31'h0, instr_start_n_oe});
      @(posedge hclk);
      #1;
      chk("istart_end", 32'h0, {31'h0, instr_start_n_oe});
      ahb(1'b1, MPFS_OFF_PORTA, 32'hFF5A);
      repeat (3) @(posedge hclk);
      #1;
      chk("pa_pins", 32'hF858, {16'h0, port_a_oe, port_a_o});
      if (mc[1]) begin
        ahb(1'b1, MPFS_OFF_PORTD, 32'hFF00);
        repeat (3) @(posedge hclk);
        #1;
        chk("rw_hi", 32'h3, {30'h0, pins.d_oe[7], pins.d_o[7]});
        for (int r = 0; r < 2; r++) begin
          v = $urandom;
          a = v[15:0];
          d = v[23:16];
          ahb(1'b1, MPFS_OFF_BUSCYC, {7'h0, r[0], d, a});
          @(posedge hclk);
          #1;
          x = {6'h0, r[0], 1'b1, 8'hFF, a};
          v = {6'h0, pins.d_o[7:6], pins.c_oe, pins.b_o, pins.c_o};
          chk("aphase", x, v);
          @(posedge hclk);
          #1;
          x = {15'h0, 1'b0, {8{~r[0]}}, r[0] ? 8'h00 : d};
          v = {15'h0, pins.d_o[6], pins.c_oe, pins.c_oe & pins.c_o};
          chk("dphase", x, v);
          repeat (3) @(posedge hclk);
          if (r == 1) begin
            ahb(1'b0, MPFS_OFF_ADDRQ, 32'h0);
            x = {24'h0, a[7:0] ^ a[15:8] ^ 8'h5A};
            chk("rbyte", x, rd & 32'hFF);
          end else begin
            #1;
            chk("mem_wr", {8'h0, a, d}, {8'h0, addr_q, wdata_q});
          end
        end
      end else begin
        for (int p = 0; p < 2; p++) begin
          v = $urandom;
          ahb(1'b1, p ? MPFS_OFF_PORTD : MPFS_OFF_PORTB, {16'h0, v[15:0]});
          repeat (3) @(posedge hclk);
          #1;
          x = p ? {16'h0, pins.d_oe, pins.d_o} : {16'h0, pins.b_oe, pins.b_o};
          chk("port_out", {16'h0, v[15:0]}, x);
        end
        ahb(1'b1, MPFS_OFF_PORTC, 32'h0);
        gpio <= 8'($urandom);
        repeat (4) @(posedge hclk);
        ahb(1'b0, MPFS_OFF_PORTC, 32'h0);
        chk("pc_in", {24'h0, gpio}, rd & 32'hFF);
      end
      $display("Test mode %0d done", m);
    end
    results();
  end
endmodule
